/* rtl/pwm_gen_b_pkg.sv */
// Constants for the generator B output-action block
package pwm_gen_b_pkg;
	localparam int          ADDR_W          = 32;
	localparam int          DATA_W          = 32;
	localparam int          ACT_W           = 2;
	localparam int          CNT_W_DEF       = 16;
	localparam logic [11:0] OFS_ACTION_CTRL = 12'h000;
	localparam logic [11:0] OFS_STATUS      = 12'h004;
	localparam logic [11:0] OFS_MASK        = 12'hFFC;
	localparam int          ACTION_CTRL_W   = 12;
	localparam int          FLD_ZERO_LSB    = 0;
	localparam int          FLD_LOAD_LSB    = 2;
	localparam int          FLD_CMP_AU_LSB  = 4;
	localparam int          FLD_CMP_AD_LSB  = 6;
	localparam int          FLD_CMP_BU_LSB  = 8;
	localparam int          FLD_CMP_BD_LSB  = 10;
	localparam int          STAT_OUT_BIT    = 0;
	localparam logic [11:0] ACTION_CTRL_RST = 12'h000;
	localparam logic        OUT_RST         = 1'b0;
	localparam logic [1:0]  ACT_HOLD        = 2'h0;
	localparam logic [1:0]  ACT_TOGGLE      = 2'h1;
	localparam logic [1:0]  ACT_LOW         = 2'h2;
	localparam logic [1:0]  ACT_HIGH        = 2'h3;
	localparam logic [1:0]  HTRANS_NONSEQ   = 2'h2;
	localparam logic        HRESP_OKAY      = 1'b0;

	typedef enum logic [1:0] {
		BUS_IDLE,
		BUS_WRITE,
		BUS_READ
	} bus_phase_t;

	// Pick one 2-bit action field out of the control word
	function automatic logic [1:0] field_of(input logic [11:0] word,
	                                        input int          lsb);
		field_of = word[lsb +: 2];
	endfunction
endpackage

/* rtl/action_apply.sv */
// Applies one 2-bit action code to the output level
`timescale 1ns/1ns
`default_nettype none
module action_apply
	import pwm_gen_b_pkg::*;
(
	input  wire logic       level_i,
	input  wire logic       fire_i,
	input  wire logic [1:0] code_i,
	output logic            level_o
);
	always_comb begin
		level_o = level_i;
		if (fire_i) begin
			case (code_i)
				ACT_HOLD:   level_o = level_i;
				ACT_TOGGLE: level_o = ~level_i;
				ACT_LOW:    level_o = 1'b0;
				ACT_HIGH:   level_o = 1'b1;
				default:    level_o = level_i;
			endcase
		end
	end
endmodule
`default_nettype wire

/* rtl/pwm_gen_b_output_actions.sv */
// Generator B output-action logic with its AHB-Lite register slave
//
// Operation
// - Comparator B match counting up applies bits 9:8, in up/down mode only.
// - Counter equal to comparator A while counting down applies bits 7:6.
// - Comparator A match counting up applies bits 5:4, in up/down mode only.
// - Counter equal to the load value applies bits 3:2.
// - Code 0 holds, 1 toggles, 2 drives low and 3 drives high.
// - Every action field is software read/write and resets to zero.
// - Counter equal to zero applies bits 1:0.
//
// Chosen here: the address map and the AHB-Lite slave port.
`timescale 1ns/1ns
`default_nettype none
module pwm_gen_b_output_actions
	import pwm_gen_b_pkg::*;
#(
	parameter int CNT_W = CNT_W_DEF
) (
	input  wire logic                       clk_i,
	input  wire logic                       rst_i,
	input  wire logic                       hsel_i,
	input  wire logic [pwm_gen_b_pkg::ADDR_W-1:0] haddr_i,
	input  wire logic [1:0]                 htrans_i,
	input  wire logic                       hwrite_i,
	input  wire logic [2:0]                 hsize_i,
	input  wire logic [pwm_gen_b_pkg::DATA_W-1:0] hwdata_i,
	input  wire logic                       hready_i,
	output logic      [pwm_gen_b_pkg::DATA_W-1:0] hrdata_o,
	output logic                            hreadyout_o,
	output logic                            hresp_o,
	input  wire logic                       cnt_en_i,
	input  wire logic [CNT_W-1:0]           cnt_i,
	input  wire logic                       count_down_i,
	input  wire logic                       up_down_mode_i,
	input  wire logic [CNT_W-1:0]           cmp_a_i,
	input  wire logic [CNT_W-1:0]           cmp_b_i,
	input  wire logic [CNT_W-1:0]           load_i,
	output logic                            gen_b_o
);
	import pwm_gen_b_pkg::*;

	logic [ACTION_CTRL_W-1:0] act_q;
	logic [ACTION_CTRL_W-1:0] act_d;
	bus_phase_t               phase_q;
	bus_phase_t               phase_d;
	logic [11:0]              addr_q;
	logic [11:0]              addr_d;
	logic [DATA_W-1:0]        rdata_q;
	logic [DATA_W-1:0]        rdata_d;
	logic                     out_q;
	logic                     out_d;
	logic                     hit_zero;
	logic                     hit_load;
	logic                     hit_a;
	logic                     hit_b;
	logic                     ev_zero;
	logic                     ev_load;
	logic                     ev_au;
	logic                     ev_ad;
	logic                     ev_bu;
	logic                     ev_bd;
	logic                     fire;
	logic [1:0]               sel_code;
	logic                     addr_phase;
	logic [11:0]              rd_addr;

	// Bus slave: zero wait states, always OKAY
	assign hreadyout_o = 1'b1;
	assign hresp_o     = HRESP_OKAY;
	assign hrdata_o    = rdata_q;
	assign gen_b_o     = out_q;

	assign addr_phase = hsel_i && hready_i && htrans_i == HTRANS_NONSEQ;
	assign rd_addr    = haddr_i[11:0] & OFS_MASK;

	always_comb begin
		phase_d = BUS_IDLE;
		addr_d  = addr_q;
		act_d   = act_q;
		rdata_d = rdata_q;
		if (phase_q == BUS_WRITE && addr_q == OFS_ACTION_CTRL) begin
			act_d = hwdata_i[ACTION_CTRL_W-1:0];
		end
		if (addr_phase) begin
			addr_d  = rd_addr;
			phase_d = hwrite_i ? BUS_WRITE : BUS_READ;
			if (!hwrite_i) begin
				// Read data comes from next-state so a write just before is seen
				case (rd_addr)
					OFS_ACTION_CTRL:
						rdata_d = {{(DATA_W-ACTION_CTRL_W){1'b0}}, act_d};
					OFS_STATUS:
						rdata_d = {{(DATA_W-1){1'b0}}, out_d};
					default:
						rdata_d = '0;
				endcase
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			phase_q <= BUS_IDLE;
			addr_q  <= 12'h000;
			act_q   <= ACTION_CTRL_RST;
			rdata_q <= 32'h00000000;
		end else begin
			phase_q <= phase_d;
			addr_q  <= addr_d;
			act_q   <= act_d;
			rdata_q <= rdata_d;
		end
	end

	// Counter events, taken only on the counter's update strobe
	assign hit_zero = cnt_i == '0;
	assign hit_load = cnt_i == load_i;
	assign hit_a    = cnt_i == cmp_a_i;
	assign hit_b    = cnt_i == cmp_b_i;

	assign ev_zero = cnt_en_i && hit_zero;
	assign ev_load = cnt_en_i && hit_load;
	assign ev_au   = cnt_en_i && hit_a && up_down_mode_i && !count_down_i;
	assign ev_ad   = cnt_en_i && hit_a && count_down_i;
	assign ev_bu   = cnt_en_i && hit_b && up_down_mode_i && !count_down_i;
	assign ev_bd   = cnt_en_i && hit_b && count_down_i;

	// Coincident events: zero, then load, then B, then A
	always_comb begin
		fire     = 1'b1;
		sel_code = ACT_HOLD;
		if (ev_zero) begin
			sel_code = field_of(act_q, FLD_ZERO_LSB);
		end else if (ev_load) begin
			sel_code = field_of(act_q, FLD_LOAD_LSB);
		end else if (ev_bu) begin
			sel_code = field_of(act_q, FLD_CMP_BU_LSB);
		end else if (ev_bd) begin
			sel_code = field_of(act_q, FLD_CMP_BD_LSB);
		end else if (ev_au) begin
			sel_code = field_of(act_q, FLD_CMP_AU_LSB);
		end else if (ev_ad) begin
			sel_code = field_of(act_q, FLD_CMP_AD_LSB);
		end else begin
			fire = 1'b0;
		end
	end

	action_apply i_action_apply (
		.level_i (out_q),
		.fire_i  (fire),
		.code_i  (sel_code),
		.level_o (out_d)
	);

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			out_q <= OUT_RST;
		end else begin
			out_q <= out_d;
		end
	end

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	sequence seq_wr_ctrl;
		addr_phase && hwrite_i && rd_addr == OFS_ACTION_CTRL;
	endsequence

	sequence seq_rd_ctrl;
		addr_phase && !hwrite_i && rd_addr == OFS_ACTION_CTRL;
	endsequence

	sequence seq_no_zero_load;
		cnt_en_i && cnt_i != '0 && cnt_i != load_i;
	endsequence

	a_zero_high: assert property (
		cnt_en_i && cnt_i == '0 && act_q[1:0] == 2'h3 |=> gen_b_o)
		else $error("zero event with code 3 did not drive high");

	a_load_low: assert property (
		cnt_en_i && cnt_i != '0 && cnt_i == load_i && act_q[3:2] == 2'h2
		|=> !gen_b_o)
		else $error("load event with code 2 did not drive low");

	a_cmp_bu_high: assert property (
		seq_no_zero_load and (up_down_mode_i && !count_down_i
		&& cnt_i == cmp_b_i && act_q[9:8] == 2'h3) |=> gen_b_o)
		else $error("comparator B up event did not drive high");

	a_cmp_bd_low: assert property (
		seq_no_zero_load and (count_down_i && cnt_i == cmp_b_i
		&& act_q[11:10] == 2'h2) |=> !gen_b_o)
		else $error("comparator B down event did not drive low");

	a_cmp_ad_high: assert property (
		seq_no_zero_load and (count_down_i && cnt_i == cmp_a_i
		&& cnt_i != cmp_b_i && act_q[7:6] == 2'h3) |=> gen_b_o)
		else $error("comparator A down event did not drive high");

	a_cmp_au_gated: assert property (
		seq_no_zero_load and (!up_down_mode_i && !count_down_i)
		|=> $stable(gen_b_o))
		else $error("up event acted outside up/down mode");

	a_toggle_flip: assert property (
		fire && sel_code == 2'h1 |=> gen_b_o != $past(gen_b_o))
		else $error("toggle action did not invert the output");

	a_idle_hold: assert property (
		!cnt_en_i |=> $stable(gen_b_o))
		else $error("output changed without a counter event");

	a_ctrl_readback: assert property (
		seq_wr_ctrl |-> ##2 act_q == $past(hwdata_i[11:0]))
		else $error("action register write did not land");

	a_ctrl_read: assert property (
		seq_rd_ctrl and (phase_q != BUS_WRITE)
		|=> hrdata_o[11:0] == $past(act_q))
		else $error("action register read back wrong value");

	a_reset_clear: assert property (
		disable iff (1'b0) $past(rst_i) |-> act_q == 12'h000 && !gen_b_o)
		else $error("fields or output not cleared by reset");
endmodule
`default_nettype wire

/* verification/tb_top.sv */
// Self-checking bench for the generator B output-action block
`timescale 1ns/1ns
`default_nettype none
module tb_top;
	import pwm_gen_b_pkg::*;
	logic        clk_i = 0, rst_i = 1, hsel = 0, hwrite = 0, cnt_en = 0;
	logic        dn = 0, md = 0, hready, hresp, gen;
	logic [1:0]  htrans = 2'h0;
	logic [2:0]  hsize = 3'h2;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd, wd;
	logic [15:0] cnt = 16'h0, ca = 16'h0, cb = 16'h0, ld = 16'h0;
	logic [11:0] ctl;
	logic        q1;
	int          err_count = 0, n_tests = 0;
	always #4 clk_i = ~clk_i;
	pwm_gen_b_output_actions i_pwm_gen_b_output_actions (
		.clk_i(clk_i), .rst_i(rst_i), .hsel_i(hsel), .haddr_i(haddr),
		.htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(hsize),
		.hwdata_i(hwdata), .hready_i(hready), .hrdata_o(hrdata),
		.hreadyout_o(hready), .hresp_o(hresp), .cnt_en_i(cnt_en),
		.cnt_i(cnt), .count_down_i(dn), .up_down_mode_i(md), .cmp_a_i(ca),
		.cmp_b_i(cb), .load_i(ld), .gen_b_o(gen));
	task automatic chk(input string nm, input logic [31:0] s, e);
		n_tests++;
		if (s !== e) begin
			err_count++;
			$display("wrong value %s expected %h seen %h", nm, e, s);
		end
	endtask
	// Single AHB-Lite word transfer; waits on hready in both phases
	task automatic xfer(input logic wr, input logic [31:0] a, wd,
	                    output logic [31:0] r);
		@(posedge clk_i);
		hsel <= 1'b1;
		htrans <= HTRANS_NONSEQ;
		haddr <= a;
		hwrite <= wr;
		do @(posedge clk_i); while (hready !== 1'b1);
		htrans <= 2'h0;
		hwdata <= wd;
		do @(posedge clk_i); while (hready !== 1'b1);
		r = hrdata;
		chk("hresp", {31'h0, hresp}, 32'h0);
		chk("hready", {31'h0, hready}, 32'h1);
	endtask
	// Highest-priority firing event picks the code, then the code acts
	function automatic logic pred(logic l, logic [11:0] c, logic en,
	                              logic [15:0] n, a, b, lv, logic d, m);
		logic [1:0] k;
		k = 2'h0;
		if (!en) k = 2'h0;
		else if (n == 16'h0) k = c[1:0];
		else if (n == lv) k = c[3:2];
		else if (n == b && m && !d) k = c[9:8];
		else if (n == b && d) k = c[11:10];
		else if (n == a && m && !d) k = c[5:4];
		else if (n == a && d) k = c[7:6];
		case (k)
			2'h1: return ~l;
			2'h2: return 1'b0;
			2'h3: return 1'b1;
			default: return l;
		endcase
	endfunction
	task automatic close_out();
		$display("comparisons %0d mismatches %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	initial begin
		#200000;
		err_count++;
		close_out();
	end
	initial begin
		void'($urandom(22617));
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		xfer(0, 32'h0, 32'h0, rd);
		chk("ctl_reset", rd, 32'h0);
		xfer(0, 32'h4, 32'h0, rd);
		chk("out_reset", rd, 32'h0);
		xfer(1, 32'h8, 32'hFFFFFFFF, rd);
		xfer(0, 32'h8, 32'h0, rd);
		chk("unmapped", rd, 32'h0);
		$display("test reset_map done");
		q1 = 1'b0;
		for (int r = 0; r < 40; r++) begin
			wd = (r == 1) ? 32'hFFFFFFFF : $urandom();
			if (r == 0)
				wd = 32'h0;
			ctl = wd[11:0];
			xfer(1, 32'h0, wd, rd);
			xfer(0, 32'h0, 32'h0, rd);
			chk("ctl_rw", rd, {20'h0, ctl});
			for (int i = 0; i < 24; i++) begin
				@(posedge clk_i);
				cnt_en <= (i < 22) ? ($urandom() % 4 != 0) : 1'b0;
				cnt <= 16'($urandom() % 4);
				ca <= 16'($urandom() % 4);
				cb <= 16'($urandom() % 4);
				ld <= 16'(1 + $urandom() % 3);
				dn <= 1'($urandom());
				md <= 1'($urandom());
				#1;
				// Level launched by this edge, from the previous inputs
				chk("gen_b", {31'h0, gen}, {31'h0, q1});
				q1 = pred(q1, ctl, cnt_en, cnt, ca, cb, ld, dn, md);
			end
			xfer(0, 32'h4, 32'h0, rd);
			chk("status", rd, {31'h0, q1});
		end
		$display("test events done");
		close_out();
	end
endmodule
`default_nettype wire
